// ===== test_usb_host_attach_iso_sched.sv
// Self-checking bench for the attach detector and isochronous scheduler.
// Assumes shortened frame, connect and window counts; inputs move on falling edges.
`timescale 1ns/10ps
module test_usb_host_attach_iso_sched;
   import usb_host_attach_iso_pkg::*;
   localparam int FR = 600;
   localparam int CN = 200;
   localparam int WN = 100;
   logic i_clk = 0, i_rst_n = 0, i_host_mode = 0, i_dp, i_dm, pd_p = 0, pd_m = 0, c_en = 0;
   logic c_clr = 0, smp = 0, defer = 0, f_clr = 0, d_clr = 0, lau = 0, lau_in = 0, p_end = 0;
   logic tx_need = 0, tx_have = 0, rx_val = 0, rx_room = 0, att = 0, low = 0;
   logic o_pdp, o_pdm, o_cc, o_int, o_conn, o_fs, o_j, o_k, o_ps, o_pin, o_ab, o_mk;
   logic o_dn, o_fi, o_sba, hit;
   logic [FNUM_W-1:0] o_fn, fn0;
   logic [RES_W-1:0] o_res;
   logic [5:0] obs;
   int failures = 0, n_tests = 0, waited;
   assign obs = {o_ab, o_dn, o_fi, o_mk, o_ps, o_cc};
   usb_periph_model i_usb_periph_model (.i_attach(att), .i_low_speed(low),
      .i_dplus_pulldown(o_pdp), .i_dminus_pulldown(o_pdm), .o_dp(i_dp), .o_dm(i_dm));
   usb_host_attach_iso_sched #(.FRAME_CYCLES(FR), .CONN_CYCLES(CN), .ISO_WIN_CYCLES(WN))
   i_usb_host_attach_iso_sched (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_host_mode(i_host_mode),
      .i_dp(i_dp), .i_dm(i_dm), .i_dplus_pulldown_enable(pd_p),
      .i_dminus_pulldown_enable(pd_m), .i_connect_change_irq_enable(c_en),
      .i_connect_change_irq_clr(c_clr), .i_bus_sample_request(smp),
      .i_iso_defer_enable(defer), .i_frame_marker_irq_clr(f_clr),
      .i_transfer_done_irq_clr(d_clr), .i_launch(lau), .i_launch_in(lau_in),
      .i_pkt_end(p_end), .i_tx_need(tx_need), .i_tx_have(tx_have), .i_rx_valid(rx_val),
      .i_rx_room(rx_room), .i_marker_busy(1'b0), .o_dplus_pulldown(o_pdp),
      .o_dminus_pulldown(o_pdm), .o_connect_change_irq(o_cc), .o_int(o_int),
      .o_connected(o_conn), .o_full_speed(o_fs), .o_j_state_flag(o_j),
      .o_k_state_flag(o_k), .o_pkt_start(o_ps), .o_pkt_in(o_pin), .o_pkt_abort(o_ab),
      .o_marker_start(o_mk), .o_frame_number(o_fn), .o_transfer_result_code(o_res),
      .o_transfer_done_irq(o_dn), .o_frame_marker_irq(o_fi), .o_send_buffer_avail_irq(o_sba));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, 4 ns period
   initial begin
      forever #2 i_clk = !i_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Waits for one watched output, bounded; hit tells whether it came
   task automatic wait_bit(input int b, input int lim);
      // Look before the first tick so a one-cycle pulse already up is not missed
      hit = (obs[b] === 1'b1);
      for (waited = 0; waited < lim && !hit; waited++) begin
         tick(1);
         hit = (obs[b] === 1'b1);
      end
   endtask : wait_bit
   task automatic pulse_end();
      p_end = 1;
      tick(1);
      p_end = 0;
   endtask : pulse_end
   // Aligns to a frame marker, clears flags, then launches early or late in the frame
   task automatic launch(input logic in, input logic dfr, input logic late);
      {tx_need, tx_have, rx_val, rx_room} = 4'h0;
      wait_bit(2, FR + 20);
      tick(late ? 540 : 5);
      {f_clr, d_clr} = 2'h3;
      tick(1);
      {f_clr, d_clr} = 2'h0;
      tick(1);
      check("frame_irq_clr", o_fi, 0);
      defer = dfr;
      {lau, lau_in} = {1'b1, in};
      tick(1);
      lau = 0;
   endtask : launch
   task automatic attach_wait(input string nm);
      wait_bit(0, CN + 40);
      check({nm, "_irq"}, hit, 1);
      check({nm, "_late_enough"}, waited + 51 >= CN - 10, 1);
   endtask : attach_wait
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the expected run of about 7800 cycles
   initial begin
      tick(40000);
      failures++;
      final_report();
   end
   // Main sequence
   initial begin
      tick(2);
      i_rst_n = 1;
      check("reset_pulldowns", {o_pdp, o_pdm}, 0);
      check("reset_flags", {o_cc, o_int, o_fi, o_dn, o_sba, o_res}, 16'h0010);
      i_host_mode = 1;
      {pd_p, pd_m} = 2'h3;
      tick(2);
      check("pulldowns", {o_pdp, o_pdm}, 2'h3);
      tick(200);
      att = 1;
      tick(50);
      smp = 1;
      tick(1);
      smp = 0;
      tick(1);
      check("sample_j", {o_j, o_k}, 2'h2);
      attach_wait("attach_fs");
      check("fs_attach", {o_conn, o_fs, o_j}, 3'h7);
      check("int_masked", o_int, 0);
      c_en = 1;
      tick(2);
      check("int_enabled", o_int, 1);
      c_en = 0;
      tick(2);
      check("int_disabled", o_int, 0);
      tick(5);
      check("flag_holds", o_cc, 1);
      c_clr = 1;
      tick(1);
      c_clr = 0;
      tick(1);
      check("flag_cleared", o_cc, 0);
      att = 0;
      tick(51);
      attach_wait("detach");
      check("detached", {o_conn, o_j, o_k}, 0);
      {c_clr, low} = 2'h3;
      tick(1);
      c_clr = 0;
      tick(200);
      att = 1;
      tick(51);
      attach_wait("attach_ls");
      check("ls_attach", {o_conn, o_fs}, 2'h2);
      $display("test attach done");
      // Early launches: OUT and IN, good and starved FIFOs, defer on and off
      for (int c = 0; c < 4; c++) begin
         launch(c[1], c[0] ^ c[1], 0);
         wait_bit(1, 5);
         check("early_start", {hit, o_pin}, {1'b1, c[1]});
         check("sba_busy", o_sba, c[1]);
         {tx_need, tx_have, rx_val, rx_room} = {!c[1], c[0], c[1], c[0]};
         tick(10);
         pulse_end();
         wait_bit(4, 5);
         check("done", hit, 1);
         check("run_result", o_res, c[0] ? 4'h0 : 4'h6);
         check("sba_back", o_sba, 1);
      end
      $display("test early done");
      launch(0, 0, 1);
      wait_bit(1, 5);
      {tx_need, tx_have} = 2'h3;
      wait_bit(5, 100);
      check("out_abort", hit, 1);
      wait_bit(3, 3);
      check("out_late_res", {hit, o_dn, o_sba, o_res}, 16'h0053);
      tick(20);
      check("out_no_done", o_dn, 0);
      launch(0, 1, 1);
      wait_bit(1, 30);
      check("out_held", {hit, o_sba}, 0);
      wait_bit(3, 100);
      check("out_held_sba", {hit, o_sba}, 2'h2);
      wait_bit(1, 10);
      check("out_after_mark", hit, 1);
      pulse_end();
      wait_bit(4, 5);
      check("out_def_res", {hit, o_res}, 5'h10);
      launch(1, 0, 1);
      wait_bit(1, 5);
      {rx_val, rx_room} = 2'h3;
      fn0 = o_fn;
      wait_bit(2, 80);
      check("in_no_marker", hit, 0);
      check("in_late_res", {o_fi, o_res}, 5'h13);
      check("fnum_step", o_fn, FNUM_W'(fn0 + 11'h001));
      pulse_end();
      tick(3);
      check("in_no_done", o_dn, 0);
      launch(1, 1, 1);
      wait_bit(1, 30);
      check("in_held", hit, 0);
      wait_bit(3, 100);
      check("in_frame_irq", hit, 1);
      wait_bit(1, 10);
      check("in_after_mark", {hit, o_pin}, 2'h3);
      {rx_val, rx_room} = 2'h3;
      tick(5);
      pulse_end();
      wait_bit(4, 5);
      check("in_def_res", {hit, o_res}, 5'h10);
      $display("test late done");
      final_report();
   end
endmodule : test_usb_host_attach_iso_sched

// ===== usb_host_attach_iso_pkg.sv
// Constants and types for the host attach detector and isochronous scheduler.
// Assumes a single 250 MHz core clock and full-speed (12 Mb/s) bit timing.
package usb_host_attach_iso_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and bus rates
   localparam longint CLK_HZ = 250000000;
   localparam longint FS_BIT_HZ = 12000000;

   // Times in their own units
   localparam longint FRAME_US = 1000;
   localparam longint CONN_US = 25;
   localparam longint SE0_MIN_BITS = 8;
   localparam longint ISO_WIN_BYTES = 256;

   // Cycle counts: least times round up, the frame period is exact
   localparam int FRAME_CYC = int'(FRAME_US * CLK_HZ / 1000000);
   localparam int CONN_CYC = int'((CONN_US * CLK_HZ + 999999) / 1000000);
   localparam int SE0_MIN_CYC = int'((SE0_MIN_BITS * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ);
   localparam int ISO_WIN_CYC = int'((ISO_WIN_BYTES * 8 * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ);

   // Widths
   localparam int CNT_W = 18;
   localparam int FNUM_W = 11;
   localparam int RES_W = 4;

   // Result codes
   localparam logic [RES_W-1:0] RES_SUCCESS = 4'h0;
   localparam logic [RES_W-1:0] RES_LATE = 4'h3;
   localparam logic [RES_W-1:0] RES_RUN_ERR = 4'h6;

   // Reset values
   localparam logic [RES_W-1:0] RST_RESULT = RES_SUCCESS;
   localparam logic RST_SEND_AVAIL = 1'b1;

   // Scheduler states, Gray along idle -> transfer -> hold -> release
   typedef enum logic [1:0] {
      SCH_IDLE = 2'b00,
      SCH_XFER = 2'b01,
      SCH_HELD = 2'b11,
      SCH_RELEASE = 2'b10
   } sched_state_t;

endpackage : usb_host_attach_iso_pkg

// ===== usb_host_attach_iso_sched.sv
// Host-side attach/detach detector, pulldown control and isochronous
// packet-versus-frame-marker scheduler.
// Assumes D+/D- arrive asynchronously; all other inputs come from logic on i_clk.
`timescale 1ns/10ps

module usb_host_attach_iso_sched #(
   parameter int FRAME_CYCLES = usb_host_attach_iso_pkg::FRAME_CYC,
   parameter int CONN_CYCLES = usb_host_attach_iso_pkg::CONN_CYC,
   parameter int ISO_WIN_CYCLES = usb_host_attach_iso_pkg::ISO_WIN_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_host_mode,
   input wire logic i_dp,
   input wire logic i_dm,
   input wire logic i_dplus_pulldown_enable,
   input wire logic i_dminus_pulldown_enable,
   input wire logic i_connect_change_irq_enable,
   input wire logic i_connect_change_irq_clr,
   input wire logic i_bus_sample_request,
   input wire logic i_iso_defer_enable,
   input wire logic i_frame_marker_irq_clr,
   input wire logic i_transfer_done_irq_clr,
   input wire logic i_launch,
   input wire logic i_launch_in,
   input wire logic i_pkt_end,
   input wire logic i_tx_need,
   input wire logic i_tx_have,
   input wire logic i_rx_valid,
   input wire logic i_rx_room,
   input wire logic i_marker_busy,
   output logic o_dplus_pulldown,
   output logic o_dminus_pulldown,
   output logic o_connect_change_irq,
   output logic o_int,
   output logic o_connected,
   output logic o_full_speed,
   output logic o_j_state_flag,
   output logic o_k_state_flag,
   output logic o_pkt_start,
   output logic o_pkt_in,
   output logic o_pkt_abort,
   output logic o_marker_start,
   output logic [usb_host_attach_iso_pkg::FNUM_W-1:0] o_frame_number,
   output logic [usb_host_attach_iso_pkg::RES_W-1:0] o_transfer_result_code,
   output logic o_transfer_done_irq,
   output logic o_frame_marker_irq,
   output logic o_send_buffer_avail_irq
);
   import usb_host_attach_iso_pkg::*;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   ////////////////////////////////////////////////////////////////////////////////
   // Line synchronisers; only the second stage is read
   logic dp_m_r, dm_m_r, dp_s_r, dm_s_r;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dp_m_r <= 1'b0;
         dm_m_r <= 1'b0;
         dp_s_r <= 1'b0;
         dm_s_r <= 1'b0;
      end else begin
         dp_m_r <= i_dp;
         dm_m_r <= i_dm;
         dp_s_r <= dp_m_r;
         dm_s_r <= dm_m_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Attach/detach detection and line status
   logic [CNT_W-1:0] run_cnt_r, run_cnt_nxt;
   logic lvl_se0_r, lvl_se0_nxt;
   logic seen_se0_r, seen_se0_nxt;
   logic conn_r, conn_nxt;
   logic fs_r, fs_nxt;
   logic cc_irq_r, cc_irq_nxt;
   logic int_r, int_nxt;
   logic j_r, j_nxt, k_r, k_nxt;
   logic dp_pd_r, dp_pd_nxt, dm_pd_r, dm_pd_nxt;
   logic se0, jk, held, attach_evt, detach_evt, cc_set;

   // Level classes and the hold-time run counter
   assign se0 = !dp_s_r && !dm_s_r;
   assign jk = dp_s_r ^ dm_s_r;
   assign held = (se0 == lvl_se0_r) && (run_cnt_r == CNT_W'(CONN_CYCLES - 2));
   assign attach_evt = i_host_mode && !conn_r && seen_se0_r && jk && held;
   assign detach_evt = conn_r && se0 && held;
   assign cc_set = attach_evt || detach_evt;

   // Next state of the detector
   always_comb begin
      run_cnt_nxt = run_cnt_r;
      lvl_se0_nxt = se0;
      seen_se0_nxt = seen_se0_r;
      conn_nxt = conn_r;
      fs_nxt = fs_r;
      j_nxt = j_r;
      k_nxt = k_r;
      if (se0 != lvl_se0_r) begin
         run_cnt_nxt = '0;
      end else if (run_cnt_r < CNT_W'(CONN_CYCLES - 1)) begin
         run_cnt_nxt = run_cnt_r + 1'b1;
      end
      if (se0 && run_cnt_r >= CNT_W'(SE0_MIN_CYC - 1)) begin
         seen_se0_nxt = 1'b1;
      end
      if (attach_evt) begin
         conn_nxt = 1'b1;
         seen_se0_nxt = 1'b0;
         fs_nxt = dp_s_r;
      end else if (detach_evt) begin
         conn_nxt = 1'b0;
      end
      if (i_bus_sample_request || cc_set) begin
         j_nxt = dp_s_r && !dm_s_r;
         k_nxt = !dp_s_r && dm_s_r;
      end
      // Set wins over a write-one clear
      cc_irq_nxt = cc_set || (cc_irq_r && !i_connect_change_irq_clr);
      int_nxt = cc_irq_nxt && i_connect_change_irq_enable;
      dp_pd_nxt = i_dplus_pulldown_enable;
      dm_pd_nxt = i_dminus_pulldown_enable;
   end

   // Detector registers; pulldowns come up off
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_cnt_r <= '0;
         lvl_se0_r <= 1'b0;
         seen_se0_r <= 1'b0;
         conn_r <= 1'b0;
         fs_r <= 1'b0;
         cc_irq_r <= 1'b0;
         int_r <= 1'b0;
         j_r <= 1'b0;
         k_r <= 1'b0;
         dp_pd_r <= 1'b0;
         dm_pd_r <= 1'b0;
      end else begin
         run_cnt_r <= run_cnt_nxt;
         lvl_se0_r <= lvl_se0_nxt;
         seen_se0_r <= seen_se0_nxt;
         conn_r <= conn_nxt;
         fs_r <= fs_nxt;
         cc_irq_r <= cc_irq_nxt;
         int_r <= int_nxt;
         j_r <= j_nxt;
         k_r <= k_nxt;
         dp_pd_r <= dp_pd_nxt;
         dm_pd_r <= dm_pd_nxt;
      end
   end

   assign o_connect_change_irq = cc_irq_r;
   assign o_int = int_r;
   assign o_connected = conn_r;
   assign o_full_speed = fs_r;
   assign o_j_state_flag = j_r;
   assign o_k_state_flag = k_r;
   assign o_dplus_pulldown = dp_pd_r;
   assign o_dminus_pulldown = dm_pd_r;

   // Detector checks
   property p_detach;
      $fell(conn_r) |-> cc_irq_r && $past(se0);
   endproperty
   a_detach: assert property (p_detach) else $error("detach without flag");

   property p_attach;
      $rose(conn_r) |-> cc_irq_r && $past(seen_se0_r) && $past(jk, 3);
   endproperty
   a_attach: assert property (p_attach) else $error("attach without flag");

   property p_cc_hold;
      cc_irq_r && !i_connect_change_irq_clr |=> cc_irq_r;
   endproperty
   a_cc_hold: assert property (p_cc_hold) else $error("flag lost without clear");

   property p_int_gate;
      !i_connect_change_irq_enable |=> !int_r;
   endproperty
   a_int_gate: assert property (p_int_gate) else $error("masked flag on pin");

   property p_sample;
      i_bus_sample_request |=> j_r == $past(dp_s_r && !dm_s_r) && k_r == $past(!dp_s_r && dm_s_r);
   endproperty
   a_sample: assert property (p_sample) else $error("line flags not sampled");

   property p_pulldown;
      ##1 1'b1 |-> dp_pd_r == $past(i_dplus_pulldown_enable);
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pulldown not following");

   c_attach: cover property ($rose(conn_r));
   c_detach: cover property ($fell(conn_r));

   ////////////////////////////////////////////////////////////////////////////////
   // Frame timer and isochronous scheduler
   sched_state_t state_r, state_nxt;
   logic [CNT_W-1:0] frame_cnt_r, frame_cnt_nxt;
   logic [FNUM_W-1:0] fnum_r, fnum_nxt;
   logic [RES_W-1:0] res_r, res_nxt;
   logic in_r, in_nxt, late_r, late_nxt, err_r, err_nxt;
   logic start_r, start_nxt, abort_r, abort_nxt, mark_r, mark_nxt;
   logic done_r, done_nxt, frm_irq_r, frm_irq_nxt, sba_r, sba_nxt;
   logic boundary, fits;

   assign boundary = i_host_mode && (frame_cnt_r == CNT_W'(FRAME_CYCLES - 1));
   assign fits = (CNT_W'(FRAME_CYCLES - 1) - frame_cnt_r) >= CNT_W'(ISO_WIN_CYCLES);

   // Next state of the scheduler
   always_comb begin
      state_nxt = state_r;
      frame_cnt_nxt = frame_cnt_r;
      fnum_nxt = fnum_r;
      res_nxt = res_r;
      in_nxt = in_r;
      late_nxt = late_r;
      err_nxt = err_r;
      start_nxt = 1'b0;
      abort_nxt = 1'b0;
      mark_nxt = boundary;
      done_nxt = done_r && !i_transfer_done_irq_clr;
      frm_irq_nxt = boundary || (frm_irq_r && !i_frame_marker_irq_clr);
      sba_nxt = sba_r;
      if (i_host_mode) begin
         frame_cnt_nxt = boundary ? '0 : frame_cnt_r + 1'b1;
      end
      if (boundary) begin
         fnum_nxt = fnum_r + 1'b1;
      end
      unique case (state_r)
         SCH_IDLE: begin
            if (i_launch) begin
               in_nxt = i_launch_in;
               late_nxt = 1'b0;
               err_nxt = 1'b0;
               if (!i_launch_in) begin
                  sba_nxt = 1'b0;
               end
               if (i_iso_defer_enable && !fits) begin
                  state_nxt = SCH_HELD;
               end else begin
                  start_nxt = 1'b1;
                  state_nxt = SCH_XFER;
               end
            end
         end
         SCH_XFER: begin
            if (!in_r && i_tx_need && !i_tx_have) begin
               err_nxt = 1'b1;
            end
            if (in_r && i_rx_valid && !i_rx_room) begin
               err_nxt = 1'b1;
            end
            if (i_pkt_end) begin
               state_nxt = SCH_IDLE;
               sba_nxt = 1'b1;
               if (!late_r) begin
                  done_nxt = 1'b1;
                  res_nxt = (err_nxt) ? RES_RUN_ERR : RES_SUCCESS;
               end
            end else if (boundary && in_r) begin
               mark_nxt = 1'b0;
               late_nxt = 1'b1;
               res_nxt = RES_LATE;
            end else if (boundary) begin
               abort_nxt = 1'b1;
               res_nxt = RES_LATE;
               sba_nxt = 1'b1;
               state_nxt = SCH_IDLE;
            end
         end
         SCH_HELD: begin
            if (boundary) begin
               state_nxt = SCH_RELEASE;
            end
         end
         SCH_RELEASE: begin
            // Wait until the marker has gone out, then send the held packet
            if (!mark_r && !i_marker_busy) begin
               start_nxt = 1'b1;
               state_nxt = SCH_XFER;
            end
         end
      endcase
   end

   // Scheduler registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= SCH_IDLE;
         frame_cnt_r <= '0;
         fnum_r <= '0;
         res_r <= RST_RESULT;
         in_r <= 1'b0;
         late_r <= 1'b0;
         err_r <= 1'b0;
         start_r <= 1'b0;
         abort_r <= 1'b0;
         mark_r <= 1'b0;
         done_r <= 1'b0;
         frm_irq_r <= 1'b0;
         sba_r <= RST_SEND_AVAIL;
      end else begin
         state_r <= state_nxt;
         frame_cnt_r <= frame_cnt_nxt;
         fnum_r <= fnum_nxt;
         res_r <= res_nxt;
         in_r <= in_nxt;
         late_r <= late_nxt;
         err_r <= err_nxt;
         start_r <= start_nxt;
         abort_r <= abort_nxt;
         mark_r <= mark_nxt;
         done_r <= done_nxt;
         frm_irq_r <= frm_irq_nxt;
         sba_r <= sba_nxt;
      end
   end

   assign o_pkt_start = start_r;
   assign o_pkt_in = in_r;
   assign o_pkt_abort = abort_r;
   assign o_marker_start = mark_r;
   assign o_frame_number = fnum_r;
   assign o_transfer_result_code = res_r;
   assign o_transfer_done_irq = done_r;
   assign o_frame_marker_irq = frm_irq_r;
   assign o_send_buffer_avail_irq = sba_r;

   // Scheduler checks
   property p_defer;
      state_r == SCH_IDLE && i_launch && i_iso_defer_enable && !fits |=> state_r == SCH_HELD && !start_r;
   endproperty
   a_defer: assert property (p_defer) else $error("late launch not held");

   property p_truncate;
      abort_r |-> res_r == RES_LATE && frm_irq_r && !$rose(done_r);
   endproperty
   a_truncate: assert property (p_truncate) else $error("truncation misreported");

   property p_held_sba;
      state_r inside {SCH_HELD, SCH_RELEASE} && !in_r |-> !sba_r;
   endproperty
   a_held_sba: assert property (p_held_sba) else $error("send buffer shown free");

   property p_in_late;
      boundary && state_r == SCH_XFER && in_r && !i_pkt_end |=> !mark_r && frm_irq_r && res_r == RES_LATE;
   endproperty
   a_in_late: assert property (p_in_late) else $error("late IN mishandled");

   property p_fnum;
      boundary |=> fnum_r == $past(fnum_r) + 1'b1;
   endproperty
   a_fnum: assert property (p_fnum) else $error("frame number not advanced");

   property p_release;
      state_r == SCH_HELD && boundary |=> mark_r && frm_irq_r && !start_r;
   endproperty
   a_release: assert property (p_release) else $error("held packet before marker");

   c_deferred: cover property (state_r == SCH_RELEASE && start_nxt);
   c_abort: cover property (abort_r);
   c_in_late: cover property (late_r && i_pkt_end);

endmodule : usb_host_attach_iso_sched

// ===== usb_periph_model.sv
// Behavioural USB peripheral seen from the host side of the attach detector.
// Assumes the host drives the pulldown enables; lines change asynchronously.
`timescale 1ns/10ps
module usb_periph_model (
   input wire logic i_attach,
   input wire logic i_low_speed,
   input wire logic i_dplus_pulldown,
   input wire logic i_dminus_pulldown,
   output logic o_dp,
   output logic o_dm
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pull-up on D+ for full speed, on D- for low speed; detached lines rest at the
   // pulldown level, and an unterminated line floats high so it never reads as SE0
   always_comb begin
      o_dp = i_attach ? !i_low_speed : !i_dplus_pulldown;
      o_dm = i_attach ? i_low_speed : !i_dminus_pulldown;
   end
endmodule : usb_periph_model
